// ==== hw/t1rx_status.sv ====
/*
 * T1 receive status, event latching, AIS-CI/RAI-CI detection, milliwatt
 * tone substitution and performance counter latching, behind an APB slave.
 * assumes the framer drives its signals from the receive line clock and
 * changes them away from that clock's rising edge; all are synchronised here.
 */
`timescale 1ns/10ps
`include "t1rx_map.svh"

// How it works
// - rx event mask bit 1 lets that event interrupt, 0 blocks it.
// - link event bits stay set until host clears; masked onto interrupt.
// - bit 0 sets on code accepted, bit 1 when code is lost.
// - bit 2 sets when 8 new data-link bits fill the holding register.
// - bit 3 sets on a valid SLC-96 alignment with data ready.
// - AIS-CI bit sets only during AIS, again each pattern burst.
// - RAI-CI bit works only in ESF during RAI, sets each burst.
// - AIS-CI signature is 6176 bits, zeros at 3088, 3474, 5790.
// - AIS-CI detection handles 1.26 s cycle, any framing format.
// - RAI-CI sets on filtered code 00111110 11111111 during RAI.
// - enabled channels carry repeating 1E 0B 0B 1E 9E 8B 8B 9E.
// - 24 tone enables in three registers, channel 1 at bit 0.
// - line-code counter saturates; the others wrap.
// - counters latch each second, 42/62.5 ms, or manually.
// - five latch modes chosen by the configuration bits.
// - config bit 0 adds excessive zeros to line-code count.
// - config bit 1 picks framing-bit errors or out-of-sync multiframes.
// - config bit 2 adds Fs errors to the path-code count.
// - config bit 3 picks timed (bit 4) or manual (bit 5) update.
// - timed update each second, or each 336/500 frames.
// - manual bit rising edge latches and resets counters next clock.
// - manual mode uses local bit or global latch by bit 6.
// - timed mode uses own second or first framer's second by bit 7.
module t1rx_status
  import t1rx_pkg::*;
#(
  parameter int T1_SEC_BITS = `T1_SEC_BITS,
  parameter int E1_SEC_BITS = `E1_SEC_BITS
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_line_clk_in,
  input wire logic rx_data_in,
  input wire logic rx_fsync_in,
  input wire logic rx_multiframe_event_in,
  input wire logic signaling_change_event_in,
  input wire logic store_slip_event_in,
  input wire logic store_empty_event_in,
  input wire logic store_full_event_in,
  input wire logic code_valid_in,
  input wire logic [15:0] code_value_in,
  input wire logic dl_bit_in,
  input wire logic dl_strobe_in,
  input wire logic slc_align_in,
  input wire logic ais_cond_in,
  input wire logic rai_cond_in,
  input wire logic esf_mode_in,
  input wire logic e1_mode_in,
  input wire logic bpv_in,
  input wire logic excess_zero_in,
  input wire logic ft_err_in,
  input wire logic fs_err_in,
  input wire logic crc_err_in,
  input wire logic oos_mf_in,
  input wire logic shared_second_in,
  input wire logic global_counter_latch_in,
  output logic bp_data_out,
  output logic rx_int_out
);
  localparam int SW = 40;

  // ----------------------------------------------------------------
  // input synchroniser and line clock edge
  // ----------------------------------------------------------------
  logic [SW-1:0] meta_q, sync_q;
  logic [SW-1:0] raw;
  logic lclk_prev_q;
  logic bit_en;
  logic lclk, din, fsync, mf_ev, sig_ev, slip_ev, emp_ev, full_ev, cvalid, dlb, dls, slc, ais_c, rai_c;
  logic esf, e1, bpv, exz, fterr, fserr, crcerr, oos, ref_sec, glatch;
  logic [15:0] cval;

  assign raw = {rx_line_clk_in, rx_data_in, rx_fsync_in, rx_multiframe_event_in, signaling_change_event_in,
                store_slip_event_in, store_empty_event_in, store_full_event_in, code_valid_in, code_value_in,
                dl_bit_in, dl_strobe_in, slc_align_in, ais_cond_in, rai_cond_in, esf_mode_in, e1_mode_in,
                bpv_in, excess_zero_in, ft_err_in, fs_err_in, crc_err_in, oos_mf_in, shared_second_in,
                global_counter_latch_in};
  assign {lclk, din, fsync, mf_ev, sig_ev, slip_ev, emp_ev, full_ev, cvalid, cval, dlb, dls, slc, ais_c,
          rai_c, esf, e1, bpv, exz, fterr, fserr, crcerr, oos, ref_sec, glatch} = sync_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
      lclk_prev_q <= 1'b0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      lclk_prev_q <= lclk;
    end
  end

  // framer outputs are taken at each rising edge of the line clock
  assign bit_en = lclk & ~lclk_prev_q;

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  logic [23:0] tone_en_q;
  logic [7:0] ecfg_q, rx_mask_q, lnk_mask_q, rx_stat_q, lnk_stat_q, dl_hold_q;
  logic [7:0] rx_set, lnk_set, wbyte;
  logic wr_en, rd_en;
  reg_id_t sel;

  function automatic reg_id_t decode(input logic [9:0] idx);
    case (idx)
      `REG_TONE1: decode = R_TONE1;
      `REG_TONE2: decode = R_TONE2;
      `REG_TONE3: decode = R_TONE3;
      `REG_LCV_HI: decode = R_LCV_HI;
      `REG_LCV_LO: decode = R_LCV_LO;
      `REG_PCV_HI: decode = R_PCV_HI;
      `REG_PCV_LO: decode = R_PCV_LO;
      `REG_FOS_HI: decode = R_FOS_HI;
      `REG_FOS_LO: decode = R_FOS_LO;
      `REG_DL_HOLD: decode = R_DL_HOLD;
      `REG_ECFG: decode = R_ECFG;
      `REG_RX_STAT: decode = R_RX_STAT;
      `REG_LNK_STAT: decode = R_LNK_STAT;
      `REG_RX_MASK: decode = R_RX_MASK;
      `REG_LNK_MASK: decode = R_LNK_MASK;
      default: decode = R_NONE;
    endcase
  endfunction : decode

  assign sel = decode(paddr_in[11:2]);
  assign wbyte = pwdata_in[7:0];
  // one wait state: the access completes on the second access cycle
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in & (sel != R_NONE);
  assign rd_en = psel_in & penable_in & ~pready_out;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tone_en_q <= '0;
      ecfg_q <= `RESET_BYTE;
      rx_mask_q <= `RESET_BYTE;
      lnk_mask_q <= `RESET_BYTE;
    end else if (wr_en) begin
      case (sel)
        R_TONE1: tone_en_q[7:0] <= wbyte;
        R_TONE2: tone_en_q[15:8] <= wbyte;
        R_TONE3: tone_en_q[23:16] <= wbyte;
        R_ECFG: ecfg_q <= wbyte;
        R_RX_MASK: rx_mask_q <= wbyte;
        R_LNK_MASK: lnk_mask_q <= wbyte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // latched status, write one to clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_stat_q <= `RESET_BYTE;
      lnk_stat_q <= `RESET_BYTE;
    end else begin
      rx_stat_q <= (rx_stat_q & ~((wr_en && sel == R_RX_STAT) ? wbyte : 8'h00)) | rx_set;
      lnk_stat_q <= (lnk_stat_q & ~((wr_en && sel == R_LNK_STAT) ? wbyte : 8'h00)) | lnk_set;
    end
  end

  // unused mask bits are ignored so a stray one cannot raise a spurious interrupt
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_int_out <= 1'b0;
    end else begin
      rx_int_out <= |(rx_stat_q & rx_mask_q & `RX_DEFINED) | |(lnk_stat_q & lnk_mask_q & `LNK_DEFINED);
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  logic [`CNT_W-1:0] lcv_held, pcv_held, fos_held;
  logic [7:0] rbyte;

  always_comb begin
    case (sel)
      R_TONE1: rbyte = tone_en_q[7:0];
      R_TONE2: rbyte = tone_en_q[15:8];
      R_TONE3: rbyte = tone_en_q[23:16];
      R_LCV_HI: rbyte = lcv_held[15:8];
      R_LCV_LO: rbyte = lcv_held[7:0];
      R_PCV_HI: rbyte = pcv_held[15:8];
      R_PCV_LO: rbyte = pcv_held[7:0];
      R_FOS_HI: rbyte = fos_held[15:8];
      R_FOS_LO: rbyte = fos_held[7:0];
      R_DL_HOLD: rbyte = dl_hold_q;
      R_ECFG: rbyte = ecfg_q;
      R_RX_STAT: rbyte = rx_stat_q;
      R_LNK_STAT: rbyte = lnk_stat_q;
      R_RX_MASK: rbyte = rx_mask_q;
      R_LNK_MASK: rbyte = lnk_mask_q;
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end else begin
      pready_out <= rd_en;
      pslverr_out <= rd_en & (sel == R_NONE);
      prdata_out <= (rd_en && !pwrite_in) ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // frame position and milliwatt tone
  // ----------------------------------------------------------------
  logic [7:0] pos_q;
  logic [2:0] frame_q;
  logic [4:0] chan;
  logic [2:0] bitn;

  function automatic logic [7:0] tone_byte(input logic [2:0] k);
    case (k)
      3'd0, 3'd3: tone_byte = 8'h1E;
      3'd1, 3'd2: tone_byte = 8'h0B;
      3'd4, 3'd7: tone_byte = 8'h9E;
      default: tone_byte = 8'h8B;
    endcase
  endfunction : tone_byte

  // position 193 (held there until a frame sync; 0 only until the first line clock edge) is the framing bit; channel bits 1 to 192 follow msb first
  assign chan = 5'((pos_q - 8'd1) >> 3);
  assign bitn = 3'((pos_q - 8'd1) & 8'h07);

  logic [7:0] tone_cur;
  assign tone_cur = tone_byte(frame_q);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos_q <= '0;
      frame_q <= '0;
      bp_data_out <= 1'b1;
    end else if (bit_en) begin
      if (fsync) begin
        pos_q <= 8'd1;
        frame_q <= frame_q + 3'd1;
      end else if (pos_q != `FRAME_BITS) begin
        pos_q <= pos_q + 8'd1;
      end
      if (pos_q != 8'd0 && pos_q < `FRAME_BITS && tone_en_q[chan]) begin
        bp_data_out <= tone_cur[3'd7 - bitn];
      end else begin
        bp_data_out <= din;
      end
    end
  end

  // ----------------------------------------------------------------
  // AIS-CI signature detector (unframed, any framing format)
  // ----------------------------------------------------------------
  logic [12:0] run_q;
  logic [1:0] phase_q, hits_q, gk;
  logic armed_q, ais_hit;

  function automatic logic [1:0] gap_kind(input logic [12:0] gap);
    case (gap)
      `AIS_GAP0: gap_kind = 2'd0;
      `AIS_GAP1: gap_kind = 2'd1;
      `AIS_GAP2: gap_kind = 2'd2;
      default: gap_kind = 2'd3;
    endcase
  endfunction : gap_kind

  assign gk = gap_kind(run_q + 13'd1);
  assign ais_hit = bit_en & ~din & (gk != 2'd3) & (gk == phase_q) & (hits_q == 2'd2);

  // re-armed only by an all-ones stretch longer than one signature, so one
  // burst of signatures gives one event per 1.26 s cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_q <= '0;
      phase_q <= '0;
      hits_q <= '0;
      armed_q <= 1'b1;
    end else if (bit_en) begin
      if (din) begin
        if (run_q != 13'h1FFF) begin
          run_q <= run_q + 13'd1;
        end
        if (run_q > `AIS_PERIOD) begin
          armed_q <= 1'b1;
        end
      end else begin
        run_q <= '0;
        phase_q <= (gk == 2'd2) ? 2'd0 : gk + 2'd1;
        if (gk == 2'd3) begin
          hits_q <= '0;
        end else if (gk == phase_q && hits_q != 2'd0) begin
          hits_q <= (hits_q == 2'd2) ? 2'd0 : hits_q + 2'd1;
        end else begin
          hits_q <= 2'd1;
        end
        if (ais_hit) begin
          armed_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link events: code, data link, SLC-96, RAI-CI
  // ----------------------------------------------------------------
  logic cvalid_q, rai_match_q, rai_match;
  logic [2:0] dl_cnt_q;
  logic [7:0] dl_shift_q;

  // code_valid_in already carries the acceptance and integration filtering
  assign rai_match = cvalid & (cval == `RAI_CI_CODE) & esf & rai_c;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cvalid_q <= 1'b0;
      rai_match_q <= 1'b0;
      dl_cnt_q <= '0;
      dl_shift_q <= '0;
      dl_hold_q <= '0;
    end else if (bit_en) begin
      cvalid_q <= cvalid;
      rai_match_q <= rai_match;
      if (dls) begin
        dl_shift_q <= {dl_shift_q[6:0], dlb};
        dl_cnt_q <= dl_cnt_q + 3'd1;
        if (dl_cnt_q == 3'd7) begin
          dl_hold_q <= {dl_shift_q[6:0], dlb};
        end
      end
    end
  end

  always_comb begin
    lnk_set = 8'h00;
    lnk_set[`LNK_BD] = bit_en & cvalid & ~cvalid_q;
    lnk_set[`LNK_BC] = bit_en & ~cvalid & cvalid_q;
    lnk_set[`LNK_DLF] = bit_en & dls & (dl_cnt_q == 3'd7);
    lnk_set[`LNK_SLC] = bit_en & slc;
    lnk_set[`LNK_AIS] = ais_hit & armed_q & ais_c;
    lnk_set[`LNK_RAI] = bit_en & rai_match & ~rai_match_q;
  end

  // ----------------------------------------------------------------
  // timers and counter latch selection
  // ----------------------------------------------------------------
  logic [21:0] sec_cnt_q;
  logic [8:0] fr_cnt_q;
  logic own_sec, short_tick, ref_prev_q, gl_prev_q, manual_update_trigger_prev_q, timed_tick, latch;

  assign own_sec = bit_en & (sec_cnt_q == 22'((e1 ? E1_SEC_BITS : T1_SEC_BITS) - 1));
  assign short_tick = bit_en & fsync & (fr_cnt_q == (e1 ? `E1_SHORT_FRAMES : `T1_SHORT_FRAMES) - 9'd1);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_cnt_q <= '0;
      fr_cnt_q <= '0;
      ref_prev_q <= 1'b0;
      gl_prev_q <= 1'b0;
      manual_update_trigger_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_sec;
      gl_prev_q <= glatch;
      manual_update_trigger_prev_q <= ecfg_q[`ECFG_MANUAL_UPDATE_TRIGGER];
      if (bit_en) begin
        sec_cnt_q <= own_sec ? 22'd0 : sec_cnt_q + 22'd1;
        if (fsync) begin
          fr_cnt_q <= short_tick ? 9'd0 : fr_cnt_q + 9'd1;
        end
      end
    end
  end

  always_comb begin
    if (ecfg_q[`ECFG_UPDATE_INTERVAL_SEL]) begin
      timed_tick = short_tick;
    end else if (ecfg_q[`ECFG_SECS]) begin
      timed_tick = ref_sec & ~ref_prev_q;
    end else begin
      timed_tick = own_sec;
    end
    if (!ecfg_q[`ECFG_ACCUMULATION_MODE_SEL]) begin
      latch = timed_tick;
    end else if (ecfg_q[`ECFG_MANUAL_SOURCE_SEL]) begin
      latch = glatch & ~gl_prev_q;
    end else begin
      latch = ecfg_q[`ECFG_MANUAL_UPDATE_TRIGGER] & ~manual_update_trigger_prev_q;
    end
  end

  always_comb begin
    rx_set = 8'h00;
    rx_set[`RX_MF] = bit_en & mf_ev;
    rx_set[`RX_TIMER] = timed_tick & ~ecfg_q[`ECFG_ACCUMULATION_MODE_SEL];
    rx_set[`RX_SEC] = own_sec;
    rx_set[`RX_SIG] = bit_en & sig_ev;
    rx_set[`RX_SLIP] = bit_en & slip_ev;
    rx_set[`RX_EMPTY] = bit_en & emp_ev;
    rx_set[`RX_FULL] = bit_en & full_ev;
  end

  // ----------------------------------------------------------------
  // performance counters
  // ----------------------------------------------------------------
  logic [2:0] inc;
  logic [`CNT_W-1:0] held [3];

  assign inc[0] = bit_en & (bpv | (ecfg_q[`ECFG_EXZ] & exz));
  assign inc[1] = bit_en & (esf ? crcerr : (fterr | (ecfg_q[`ECFG_FS] & fserr)));
  assign inc[2] = bit_en & (ecfg_q[`ECFG_MOS] ? oos : (fterr | (esf & crcerr)));

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    perf_counter #(.SATURATE(i == 0)) u_cnt (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .inc_in(inc[i]),
      .latch_in(latch),
      .held_out(held[i])
    );
  end

  assign lcv_held = held[0];
  assign pcv_held = held[1];
  assign fos_held = held[2];
endmodule : t1rx_status

// ==== hw/t1rx_map.svh ====
/*
 * register indices, field positions, reset values and timing counts of the
 * T1 receive status block. Included by the package and the design files.
 */
`ifndef T1RX_MAP_SVH
`define T1RX_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define REG_TONE1 10'h03C
`define REG_TONE2 10'h03D
`define REG_TONE3 10'h03E
`define REG_LCV_HI 10'h050
`define REG_LCV_LO 10'h051
`define REG_PCV_HI 10'h052
`define REG_PCV_LO 10'h053
`define REG_FOS_HI 10'h054
`define REG_FOS_LO 10'h055
`define REG_DL_HOLD 10'h060
`define REG_ECFG 10'h086
`define REG_RX_STAT 10'h093
`define REG_LNK_STAT 10'h096
`define REG_RX_MASK 10'h0A3
`define REG_LNK_MASK 10'h0A6

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ECFG_EXZ 0
`define ECFG_MOS 1
`define ECFG_FS 2
`define ECFG_ACCUMULATION_MODE_SEL 3
`define ECFG_UPDATE_INTERVAL_SEL 4
`define ECFG_MANUAL_UPDATE_TRIGGER 5
`define ECFG_MANUAL_SOURCE_SEL 6
`define ECFG_SECS 7
`define RX_MF 0
`define RX_TIMER 1
`define RX_SEC 2
`define RX_SIG 3
`define RX_SLIP 5
`define RX_EMPTY 6
`define RX_FULL 7
`define LNK_BD 0
`define LNK_BC 1
`define LNK_DLF 2
`define LNK_SLC 3
`define LNK_AIS 4
`define LNK_RAI 5
`define RX_DEFINED 8'hEF
`define LNK_DEFINED 8'h3F
`define RESET_BYTE 8'h00

// ----------------------------------------------------------------
// pattern and timing constants
// ----------------------------------------------------------------
`define AIS_PERIOD 13'd6176
`define AIS_GAP0 13'd386
`define AIS_GAP1 13'd2316
`define AIS_GAP2 13'd3474
`define RAI_CI_CODE 16'h3EFF
`define FRAME_BITS 8'd193
`define T1_SHORT_FRAMES 9'd336
`define E1_SHORT_FRAMES 9'd500
`define T1_SEC_BITS 1544000
`define E1_SEC_BITS 2048000
`define CNT_W 16

`endif

// ==== hw/t1rx_pkg.sv ====
/*
 * types shared by the T1 receive status block.
 * assumes t1rx_map.svh is on the include path.
 */
package t1rx_pkg;
`include "t1rx_map.svh"

  typedef enum logic [3:0] {
    R_NONE, R_TONE1, R_TONE2, R_TONE3, R_LCV_HI, R_LCV_LO, R_PCV_HI, R_PCV_LO,
    R_FOS_HI, R_FOS_LO, R_DL_HOLD, R_ECFG, R_RX_STAT, R_LNK_STAT, R_RX_MASK, R_LNK_MASK
  } reg_id_t;

endpackage : t1rx_pkg

// ==== hw/perf_counter.sv ====
/*
 * one performance counter with a latched, readable copy.
 * assumes inc_in and latch_in are one-cycle pulses on clk_in.
 */
`timescale 1ns/10ps
`include "t1rx_map.svh"
module perf_counter #(
  parameter bit SATURATE = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic inc_in,
  input wire logic latch_in,
  output logic [`CNT_W-1:0] held_out
);
  logic [`CNT_W-1:0] cnt_q;

  // a latch restarts the count; an increment in the same cycle is kept
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      held_out <= '0;
    end else if (latch_in) begin
      held_out <= cnt_q;
      cnt_q <= {{(`CNT_W-1){1'b0}}, inc_in};
    end else if (inc_in) begin
      if (!(SATURATE && (&cnt_q))) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : perf_counter

// ==== bench/t1rx_status_properties.sv ====
/*
 * port checks for the T1 receive status block.
 * assumes one APB wait cycle and registered outputs.
 */
`timescale 1ns/10ps
module t1rx_status_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic bp_data_out,
  input wire logic rx_int_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  access_answer_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no answer after access");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("pready without access");
  error_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr alone");
  unmapped_error_a: assert property (
    psel_in && penable_in && !pready_out && paddr_in[11:2] == 10'h3FF |=> pslverr_out)
    else $error("unmapped not refused");
  idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside completion");
  byte_data_a: assert property (prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  tone_idle_a: assert property ($rose(rst_b_in) |-> bp_data_out)
    else $error("backplane not idle");
  int_idle_a: assert property ($rose(rst_b_in) |-> !rx_int_out && !pready_out)
    else $error("outputs active after reset");
endmodule : t1rx_status_chk

bind t1rx_status t1rx_status_chk i_t1rx_status_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .bp_data_out(bp_data_out), .rx_int_out(rx_int_out));

// ==== bench/t1_framer_model.sv ====
/*
 * receive framer model: free line clock, 193-bit frames, alternating data.
 * assumes nothing of the bench; outputs change on the line falling edge.
 */
`timescale 1ns/10ps
module t1_framer_model (
  output logic line_clk_out,
  output logic data_out,
  output logic fsync_out,
  output logic [7:0] pos_out
);
  // offset keeps line edges clear of the system clock edges
  initial begin
    line_clk_out = 1'b0;
    pos_out = 8'd0;
    data_out = 1'b0;
    fsync_out = 1'b1;
    #3;
    forever begin
      #32 line_clk_out = 1'b1;
      #32 line_clk_out = 1'b0;
      pos_out = (pos_out == 8'd192) ? 8'd0 : pos_out + 8'd1;
      fsync_out = (pos_out == 8'd0);
      data_out = pos_out[0];
    end
  end
endmodule : t1_framer_model

// ==== bench/test_t1_rx_status_and_error_count_ctrl.sv ====
/*
 * bench for the T1 receive status block: registers, events, tone, counters.
 * assumes t1rx_map.svh on the include path and the framer model.
 */
`timescale 1ns/10ps
`include "t1rx_map.svh"
module test_t1_rx_status_and_error_count_ctrl import t1rx_pkg::*; ;
  typedef struct {logic w; logic [9:0] idx; logic [7:0] d; logic err;} row_t;
  logic clk_in = 1'b0, rst_b_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, lclk, ldata, fsync, bp, irq, err, ok, hit;
  logic [20:0] sig = 21'h0;
  logic [15:0] code = 16'h3EFF;
  logic [7:0] pos, sh;
  logic [7:0] got [8];
  logic [7:0] tone [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
  int error_cnt = 0, cmp_count = 0;
  row_t rows [11] = '{'{1'b1, `REG_TONE1, 8'h5A, 1'b0}, '{1'b0, `REG_TONE1, 8'h5A, 1'b0},
    '{1'b1, `REG_TONE3, 8'hC3, 1'b0}, '{1'b0, `REG_TONE3, 8'hC3, 1'b0},
    '{1'b1, `REG_ECFG, 8'h81, 1'b0}, '{1'b0, `REG_ECFG, 8'h81, 1'b0},
    '{1'b1, `REG_RX_MASK, 8'hEF, 1'b0}, '{1'b0, `REG_RX_MASK, 8'hEF, 1'b0},
    '{1'b1, `REG_LNK_MASK, 8'h3F, 1'b0}, '{1'b0, `REG_LNK_MASK, 8'h3F, 1'b0},
    '{1'b0, 10'h3FF, 8'h00, 1'b1}};

  // short seconds keep the timer events inside the run
  t1rx_status #(.T1_SEC_BITS(400), .E1_SEC_BITS(400)) i_t1rx_status (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_line_clk_in(lclk),
    .rx_data_in(ldata), .rx_fsync_in(fsync), .rx_multiframe_event_in(sig[0]),
    .signaling_change_event_in(sig[1]), .store_slip_event_in(sig[2]), .store_empty_event_in(sig[3]),
    .store_full_event_in(sig[4]), .code_valid_in(sig[13]), .code_value_in(code), .dl_bit_in(sig[14]),
    .dl_strobe_in(sig[5]), .slc_align_in(sig[6]), .ais_cond_in(sig[15]), .rai_cond_in(sig[16]),
    .esf_mode_in(sig[17]), .e1_mode_in(sig[18]), .bpv_in(sig[7]), .excess_zero_in(sig[8]),
    .ft_err_in(sig[9]), .fs_err_in(sig[10]), .crc_err_in(sig[11]), .oos_mf_in(sig[12]),
    .shared_second_in(sig[19]), .global_counter_latch_in(sig[20]), .bp_data_out(bp), .rx_int_out(irq));
  t1_framer_model i_t1_framer_model (.line_clk_out(lclk), .data_out(ldata), .fsync_out(fsync), .pos_out(pos));

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rd_chk

  // framer inputs change just after a line falling edge, so they stand over one rising edge
  task automatic set(input int b, input logic v);
    @(negedge lclk);
    @(posedge clk_in);
    sig[b] <= v;
  endtask : set

  task automatic pulse(input int b);
    set(b, 1'b1);
    set(b, 1'b0);
  endtask : pulse

  task automatic irq_chk(input logic exp);
    repeat (4) @(posedge clk_in);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (99000) @(posedge clk_in);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].d);
      chk({31'h0, err}, {31'h0, rows[i].err});
      if (!rows[i].w) chk(rd, {24'h0, rows[i].d});
    end
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd_chk(`REG_ECFG, 8'h00);
    rd_chk(`REG_RX_MASK, 8'h00);
    rd_chk(`REG_LNK_MASK, 8'h00);
    set(15, 1'b1);
    set(16, 1'b1);
    set(17, 1'b1);
    set(13, 1'b1);
    repeat (40) @(posedge clk_in);
    rd_chk(`REG_LNK_STAT, 8'h21);
    irq_chk(1'b0);
    set(13, 1'b0);
    pulse(6);
    repeat (8) pulse(5);
    repeat (40) @(posedge clk_in);
    rd_chk(`REG_LNK_STAT, 8'h2F);
    apb(1'b1, `REG_LNK_MASK, 8'h04);
    irq_chk(1'b1);
    apb(1'b1, `REG_LNK_STAT, 8'h2F);
    rd_chk(`REG_LNK_STAT, 8'h00);
    irq_chk(1'b0);
    set(17, 1'b0);
    set(13, 1'b1);
    repeat (40) @(posedge clk_in);
    rd_chk(`REG_LNK_STAT, 8'h01);
    for (int b = 0; b < 5; b++) pulse(b);
    repeat (3400) @(posedge clk_in);
    rd_chk(`REG_RX_STAT, 8'hEF);
    apb(1'b1, `REG_RX_MASK, 8'h01);
    irq_chk(1'b1);
    apb(1'b1, `REG_RX_STAT, 8'h01);
    irq_chk(1'b0);
    apb(1'b1, `REG_ECFG, 8'h08);
    repeat (3) pulse(7);
    repeat (2) pulse(8);
    apb(1'b1, `REG_ECFG, 8'h28);
    repeat (31250) @(posedge clk_in);
    rd_chk(`REG_LCV_LO, 8'h03);
    apb(1'b1, `REG_ECFG, 8'h09);
    repeat (2) pulse(8);
    apb(1'b1, `REG_ECFG, 8'h29);
    repeat (31250) @(posedge clk_in);
    rd_chk(`REG_LCV_LO, 8'h02);
    apb(1'b1, `REG_ECFG, 8'h48);
    pulse(7);
    pulse(9);
    pulse(10);
    set(20, 1'b1);
    repeat (40) @(posedge clk_in);
    rd_chk(`REG_LCV_LO, 8'h01);
    rd_chk(`REG_PCV_LO, 8'h01);
    rd_chk(`REG_FOS_LO, 8'h01);
    apb(1'b1, `REG_ECFG, 8'h80);
    repeat (2) pulse(7);
    set(19, 1'b1);
    repeat (40) @(posedge clk_in);
    rd_chk(`REG_LCV_LO, 8'h02);
    apb(1'b1, `REG_TONE1, 8'h01);
    apb(1'b1, `REG_TONE2, 8'h00);
    apb(1'b1, `REG_TONE3, 8'h00);
    do @(posedge lclk); while (pos !== 8'd1);
    for (int f = 0; f < 8; ) begin
      @(posedge lclk);
      if (pos >= 8'd2 && pos <= 8'd17) sh = {sh[6:0], bp};
      if (pos == 8'd9) got[f] = sh;
      if (pos == 8'd17) begin
        chk({24'h0, sh}, 32'h000000AA);
        f++;
      end
    end
    ok = 1'b0;
    for (int k = 0; k < 8; k++) begin
      hit = 1'b1;
      for (int i = 0; i < 8; i++) if (got[i] !== tone[(k + i) % 8]) hit = 1'b0;
      if (hit) ok = 1'b1;
    end
    chk({31'h0, ok}, 32'h1);
    end_sim();
  end
endmodule : test_t1_rx_status_and_error_count_ctrl
